// *** rtl/sacc_regs.svh ***
// Register map, field positions, reset values and sequence counts of the converter control
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH
`define SACC_ADDR_W      5
`define SACC_OFF_CTRL_A  5'h00
`define SACC_OFF_CTRL_B  5'h04
`define SACC_OFF_RES_HI  5'h08
`define SACC_OFF_RES_LO  5'h0C
`define SACC_OFF_IRQ     5'h10
`define SACC_A_START     0
`define SACC_A_POWER     1
`define SACC_A_FORMAT    2
`define SACC_A_BUSY      3
`define SACC_A_CHANNEL   7:4
`define SACC_B_DIVIDER   2:0
`define SACC_B_SOURCE    5:3
`define SACC_B_REFSEL    7:6
`define SACC_I_FLAG      0
`define SACC_I_CONV_EN   1
`define SACC_I_GLOBAL_EN 2
`define SACC_RST_BYTE    8'h00
`define SACC_SRC_EXT     3'h0
`define SACC_SRC_EXT_LO  3'h5
`define SACC_REF_VDD     2'h1
`define SACC_SAMPLE_CLKS 5'h04
`define SACC_CONV_CLKS   5'h0C
`define SACC_TOTAL_CLKS  5'h10
`define SACC_SAR_FIRST   12'h800
`define SACC_RESP_OKAY   2'h0
`define SACC_RESP_DECERR 2'h3
`endif

// *** rtl/sacc_pkg.sv ***
// Types shared by the converter control
package sacc_pkg;
  typedef enum logic [1:0] {SACC_IDLE, SACC_SAMPLE, SACC_CONVERT} sacc_state_type;
  typedef logic [11:0] sacc_code_type;
endpackage

// *** rtl/sacc_top.sv ***
// Conversion sequencer, SAR register and AXI4-Lite register file of the 12-bit converter
`timescale 1ns/1ps
`include "sacc_regs.svh"
module sacc_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [`SACC_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output wire logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output wire logic                        s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [`SACC_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output wire logic                        s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        comparator_in,
  output wire logic                        analog_power_en,
  output wire logic                        sample_en,
  output sacc_pkg::sacc_code_type          dac_code,
  output wire logic [2:0]                  input_source_select,
  output wire logic [3:0]                  channel_select,
  output wire logic                        external_input_sel,
  output wire logic                        ref_sel_vdd,
  output wire logic                        conv_irq
);
  import sacc_pkg::*;

  // One trial of the successive approximation: keep or drop bit idx, try the next one down
  function automatic sacc_code_type sacc_sar_step(input sacc_code_type code, input logic [3:0] idx,
                                                  input logic cmp);
    sacc_code_type r;
    r = code;
    r[idx] = cmp;
    if (idx != 4'h0) begin
      r[idx - 4'h1] = 1'b1;
    end
    return r;
  endfunction

  logic [7:0]     conv_control_reg_a;
  logic [7:0]     conv_control_reg_b;
  logic [2:0]     irq_bits;
  sacc_state_type state;
  logic [3:0]     phase_cnt;
  sacc_code_type  sar;
  sacc_code_type  result;
  logic [6:0]     div_cnt;
  logic           start_q;
  logic           cmp_meta;
  logic           cmp_sync;

  wire logic       start_bit            = conv_control_reg_a[`SACC_A_START];
  wire logic       conv_power_enable    = conv_control_reg_a[`SACC_A_POWER];
  wire logic       result_format_select = conv_control_reg_a[`SACC_A_FORMAT];
  wire logic [2:0] conv_clock_divider   = conv_control_reg_b[`SACC_B_DIVIDER];
  wire logic [1:0] reference_select     = conv_control_reg_b[`SACC_B_REFSEL];
  wire logic       conv_irq_request_flag = irq_bits[`SACC_I_FLAG];
  wire logic       conv_irq_enable      = irq_bits[`SACC_I_CONV_EN];
  wire logic       global_irq_enable    = irq_bits[`SACC_I_GLOBAL_EN];
  wire logic       conv_busy_flag       = (state != SACC_IDLE);
  wire logic       start_fall           = start_q & ~start_bit;
  wire logic       hold_reset           = start_bit | ~conv_power_enable;
  wire logic [6:0] div_mask             = 7'h7F >> (3'h7 - conv_clock_divider);
  wire logic       conv_tick            = ((div_cnt & div_mask) == div_mask);
  wire logic [3:0] bit_idx              = 4'hB - phase_cnt;
  wire sacc_code_type sar_next          = sacc_sar_step(sar, bit_idx, cmp_sync);
  wire logic       last_sample          = (phase_cnt == 4'(`SACC_SAMPLE_CLKS - 5'h01));
  wire logic       last_trial           = (phase_cnt == 4'(`SACC_CONV_CLKS - 5'h01));
  wire logic       conv_done            = ~hold_reset & conv_tick & (state == SACC_CONVERT) & last_trial;

  // Comparator comes from the analog domain; two stages cost two system clocks, so at a
  // divider of 0 or 1 the trial decision lags the DAC code and codes are not meaningful
  always_ff @(posedge aclk) begin
    cmp_meta <= comparator_in;
    cmp_sync <= cmp_meta;
  end

  // Converter clock as an enable; restarted at each start edge so every conversion aligns
  always_ff @(posedge aclk) begin
    if (!aresetn || start_fall) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_bit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= SACC_IDLE;
      phase_cnt <= 4'h0;
      sar       <= '0;
      result    <= '0;
    end else if (hold_reset) begin
      state     <= SACC_IDLE;
      phase_cnt <= 4'h0;
    end else if (start_fall) begin
      state     <= SACC_SAMPLE;
      phase_cnt <= 4'h0;
    end else if (conv_tick) begin
      unique case (state)
        SACC_IDLE: begin
        end
        SACC_SAMPLE: begin
          if (last_sample) begin
            state     <= SACC_CONVERT;
            phase_cnt <= 4'h0;
            sar       <= `SACC_SAR_FIRST;
          end else begin
            phase_cnt <= phase_cnt + 4'h1;
          end
        end
        SACC_CONVERT: begin
          sar <= sar_next;
          if (last_trial) begin
            state  <= SACC_IDLE;
            result <= sar_next;
          end else begin
            phase_cnt <= phase_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // Code n stands for n steps of reference/4096; the DAC is built with the half-step
  // offset so transitions land half a step early and the last one 1.5 steps below full scale
  assign dac_code            = sar;
  assign sample_en           = (state == SACC_SAMPLE);
  assign analog_power_en     = conv_power_enable;
  assign input_source_select = conv_control_reg_b[`SACC_B_SOURCE];
  assign channel_select      = conv_control_reg_a[`SACC_A_CHANNEL];
  assign external_input_sel  = (input_source_select == `SACC_SRC_EXT) ||
                               (input_source_select >= `SACC_SRC_EXT_LO);
  assign ref_sel_vdd         = (reference_select == `SACC_REF_VDD);
  assign conv_irq            = conv_irq_request_flag & conv_irq_enable & global_irq_enable;

  wire logic [7:0] result_high_byte = result_format_select ? {4'h0, result[11:8]} : result[11:4];
  wire logic [7:0] result_low_byte  = result_format_select ? result[7:0] : {result[3:0], 4'h0};

  // Bus: both write channels taken together; answers never wait on the sequencer
  wire logic wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire logic rd_take = s_axi_arvalid & ~s_axi_rvalid;
  wire logic wr_lane = wr_take & s_axi_wstrb[0];
  wire logic wr_a    = wr_lane && (s_axi_awaddr == `SACC_OFF_CTRL_A);
  wire logic wr_b    = wr_lane && (s_axi_awaddr == `SACC_OFF_CTRL_B);
  wire logic wr_i    = wr_lane && (s_axi_awaddr == `SACC_OFF_IRQ);
  wire logic wr_hit  = (s_axi_awaddr == `SACC_OFF_CTRL_A) || (s_axi_awaddr == `SACC_OFF_CTRL_B) ||
                       (s_axi_awaddr == `SACC_OFF_RES_HI) || (s_axi_awaddr == `SACC_OFF_RES_LO) ||
                       (s_axi_awaddr == `SACC_OFF_IRQ);
  wire logic [7:0] status_a = {conv_control_reg_a[7:4], conv_busy_flag, conv_control_reg_a[2:0]};
  wire logic [7:0] rd_byte  = (s_axi_araddr == `SACC_OFF_CTRL_A) ? status_a :
                              (s_axi_araddr == `SACC_OFF_CTRL_B) ? conv_control_reg_b :
                              (s_axi_araddr == `SACC_OFF_RES_HI) ? result_high_byte :
                              (s_axi_araddr == `SACC_OFF_RES_LO) ? result_low_byte :
                              (s_axi_araddr == `SACC_OFF_IRQ)    ? {5'h00, irq_bits} : `SACC_RST_BYTE;
  wire logic rd_hit = (s_axi_araddr == `SACC_OFF_CTRL_A) || (s_axi_araddr == `SACC_OFF_CTRL_B) ||
                      (s_axi_araddr == `SACC_OFF_RES_HI) || (s_axi_araddr == `SACC_OFF_RES_LO) ||
                      (s_axi_araddr == `SACC_OFF_IRQ);

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_control_reg_a <= `SACC_RST_BYTE;
      conv_control_reg_b <= `SACC_RST_BYTE;
    end else begin
      if (wr_a) begin
        conv_control_reg_a <= s_axi_wdata[7:0];
      end
      if (wr_b) begin
        conv_control_reg_b <= s_axi_wdata[7:0];
      end
    end
  end

  // Flag is write-one-to-clear; a completion in the same cycle as the clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_bits <= 3'h0;
    end else begin
      if (wr_i) begin
        irq_bits[2:1] <= s_axi_wdata[2:1];
      end
      if (conv_done) begin
        irq_bits[`SACC_I_FLAG] <= 1'b1;
      end else if (wr_i && s_axi_wdata[`SACC_I_FLAG]) begin
        irq_bits[`SACC_I_FLAG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SACC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `SACC_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SACC_RESP_OKAY : `SACC_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_hit ? `SACC_RESP_OKAY : `SACC_RESP_DECERR;
        s_axi_rdata  <= {24'h000000, rd_byte};
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks: converter ticks seen since the start edge
  logic [4:0] busy_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || start_fall) begin
      busy_ticks <= 5'h00;
    end else if (conv_busy_flag && conv_tick && !hold_reset) begin
      busy_ticks <= busy_ticks + 5'h01;
    end
  end

  sequence s_start;
    start_fall && conv_power_enable;
  endsequence
  sequence s_running;
    conv_busy_flag;
  endsequence

  property p_sample_len;
    @(posedge aclk) disable iff (!aresetn)
      (state == SACC_CONVERT) && $past(state) == SACC_SAMPLE |-> busy_ticks == `SACC_SAMPLE_CLKS;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sampling phase not four clocks");

  property p_total_len;
    @(posedge aclk) disable iff (!aresetn)
      conv_done |-> busy_ticks == (`SACC_TOTAL_CLKS - 5'h01);
  endproperty
  a_total_len: assert property (p_total_len) else $error("conversion not sixteen clocks");

  property p_start_begins;
    @(posedge aclk) disable iff (!aresetn)
      s_start |=> s_running ##0 sample_en;
  endproperty
  a_start_begins: assert property (p_start_begins) else $error("start edge did not begin sampling");

  property p_start_holds;
    @(posedge aclk) disable iff (!aresetn)
      start_bit |=> !conv_busy_flag;
  endproperty
  a_start_holds: assert property (p_start_holds) else $error("busy while start held high");

  property p_busy_phase;
    @(posedge aclk) disable iff (!aresetn)
      s_running |-> (sample_en || state == SACC_CONVERT);
  endproperty
  a_busy_phase: assert property (p_busy_phase) else $error("busy outside a conversion phase");

  property p_done_result;
    @(posedge aclk) disable iff (!aresetn)
      conv_done |=> !conv_busy_flag && result == $past(sar_next) && conv_irq_request_flag;
  endproperty
  a_done_result: assert property (p_done_result) else $error("completion did not post result");

  property p_flag_with_busy;
    @(posedge aclk) disable iff (!aresetn)
      $rose(conv_irq_request_flag) |-> $fell(conv_busy_flag);
  endproperty
  a_flag_with_busy: assert property (p_flag_with_busy) else $error("request flag apart from busy fall");

  property p_power_off;
    @(posedge aclk) disable iff (!aresetn)
      !conv_power_enable |-> !analog_power_en ##1 !conv_busy_flag;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter active with power off");

  property p_ref_sel;
    @(posedge aclk) disable iff (!aresetn)
      ref_sel_vdd == (conv_control_reg_b[`SACC_B_REFSEL] == `SACC_REF_VDD);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select decode wrong");

  property p_ext_sel;
    @(posedge aclk) disable iff (!aresetn)
      (conv_control_reg_b[5:3] inside {3'h1, 3'h2, 3'h3, 3'h4}) == !external_input_sel;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("external source decode wrong");

endmodule // sacc_top

// *** verification/sacc_top_tb_top.sv ***
// Self-checking bench for the converter control: register bus, sequencing and result bytes
`timescale 1ns/1ps
`include "sacc_regs.svh"
module sacc_top_tb_top;
  import sacc_pkg::*;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  logic [`SACC_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]             wdata = '0, rdata;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic [1:0]              bresp, rresp, resp;
  logic                    comparator_in = 1'b0;
  logic                    analog_power_en, sample_en, external_input_sel, ref_sel_vdd, conv_irq;
  sacc_code_type           dac_code, target = '0;
  logic [2:0]              input_source_select;
  logic [3:0]              channel_select;
  logic [31:0]             rd_val;
  int                      failures = 0, n_tests = 0, s_cnt = 0, n;
  time                     t0;

  always #2 aclk = ~aclk;

  sacc_top u_sacc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_in(comparator_in),
    .analog_power_en(analog_power_en), .sample_en(sample_en), .dac_code(dac_code),
    .input_source_select(input_source_select), .channel_select(channel_select),
    .external_input_sel(external_input_sel), .ref_sel_vdd(ref_sel_vdd), .conv_irq(conv_irq));

  // Ideal comparator: high while the held input is at or above the trial code
  always @(posedge aclk) comparator_in <= (target >= dac_code);
  always @(negedge aclk) if (sample_en === 1'b1) s_cnt++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Ready and valid are looked at on the falling edge, so the value seen is the one the next rising edge samples
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge aclk);
    awvalid <= 1'b0; wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(negedge aclk);
    @(posedge aclk);
    rd_val = rdata; resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SACC_OFF_CTRL_A); chk(rd_val, 32'h0);
    rd(`SACC_OFF_CTRL_B); chk(rd_val, 32'h0);
    rd(`SACC_OFF_IRQ); chk(rd_val, 32'h0);
    rd(5'h14); chk(rd_val, 32'h0);
    chk(resp, `SACC_RESP_DECERR);
    wr(5'h14, 32'hFF); chk(resp, `SACC_RESP_DECERR);
    for (int s = 0; s < 8; s++) begin
      wr(`SACC_OFF_CTRL_B, {24'h0, 2'b01, s[2:0], 3'h3});
      chk(input_source_select, s[2:0]);
      chk(external_input_sel, (s == 0 || s >= 5));
    end
    for (int v = 0; v < 4; v++) begin
      wr(`SACC_OFF_CTRL_B, {24'h0, v[1:0], 3'h0, 3'h3});
      chk(ref_sel_vdd, (v == 1));
    end
    wr(`SACC_OFF_CTRL_A, 32'h50); chk(channel_select, 4'h5);
    wr(`SACC_OFF_CTRL_A, 32'hA0); chk(channel_select, 4'hA);
    wr(`SACC_OFF_CTRL_B, 32'h4B);
    // Start pulse with the power bit low must leave the converter idle
    wr(`SACC_OFF_CTRL_A, 32'h01);
    wr(`SACC_OFF_CTRL_A, 32'h00);
    chk(analog_power_en, 1'b0);
    repeat (150) @(posedge aclk);
    rd(`SACC_OFF_IRQ); chk(rd_val, 32'h0);
    chk(s_cnt, 0);
    for (int i = 0; i < 3; i++) begin
      target = (i == 0) ? 12'hFFF : (i == 1) ? 12'hA5C : 12'h000;
      wr(`SACC_OFF_IRQ, 32'h07);
      wr(`SACC_OFF_CTRL_A, 32'h02);
      repeat (20) @(posedge aclk);
      wr(`SACC_OFF_CTRL_A, 32'h03);
      s_cnt = 0;
      wr(`SACC_OFF_CTRL_A, 32'h02);
      t0 = $time;
      rd(`SACC_OFF_CTRL_A); chk(rd_val, 32'h0A);
      chk(analog_power_en, 1'b1);
      n = 0;
      while (conv_irq !== 1'b1 && n < 2000) begin
        @(negedge aclk);
        n++;
      end
      n = ($time - t0 + 2) / 4;
      chk(n >= 128 && n <= 131, 1'b1);
      chk(s_cnt, 32);
      rd(`SACC_OFF_IRQ); chk(rd_val, 32'h07);
      rd(`SACC_OFF_CTRL_A); chk(rd_val, 32'h02);
      rd(`SACC_OFF_RES_HI); chk(rd_val, {24'h0, target[11:4]});
      rd(`SACC_OFF_RES_LO); chk(rd_val, {24'h0, target[3:0], 4'h0});
      wr(`SACC_OFF_CTRL_A, 32'h06);
      rd(`SACC_OFF_RES_HI); chk(rd_val, {28'h0, target[11:8]});
      rd(`SACC_OFF_RES_LO); chk(rd_val, {24'h0, target[7:0]});
      wr(`SACC_OFF_IRQ, 32'h07);
      chk(conv_irq, 1'b0);
    end
    // Raising start in mid-conversion aborts: no flag, busy drops
    wr(`SACC_OFF_CTRL_A, 32'h03);
    wr(`SACC_OFF_CTRL_A, 32'h02);
    repeat (40) @(posedge aclk);
    wr(`SACC_OFF_CTRL_A, 32'h03);
    repeat (200) @(posedge aclk);
    rd(`SACC_OFF_IRQ); chk(rd_val, 32'h06);
    rd(`SACC_OFF_CTRL_A); chk(rd_val, 32'h03);
    conclude();
  end
endmodule // sacc_top_tb_top
